// ==== design/dcr_regs.sv ====
// line control register bank, registers one to five, on the serial port clock
`timescale 1ns/100ps
`include "dcr_defs.svh"
module dcr_regs #(
  parameter int RING_HOLD_CYC    = `DCR_RING_HOLD_MS * (1000000 / `DCR_CLK_NS),
  parameter int OFFHOOK_HOLD_CYC = `DCR_OFFHOOK_HOLD_US * 1000 / `DCR_CLK_NS
) (
  input  wire logic          CLOCK,
  input  wire logic          RST_N,
  input  wire dcr_pkg::dcr_req_t REQ,
  input  wire logic          RING_NEG,
  input  wire logic          RING_POS,
  input  wire logic          FRAME_LOCK,
  input  wire logic          OFFHOOK_PIN,
  input  wire logic          PIN_HOOK_ENABLE,
  input  wire logic          MODE,
  output logic [7:0]         RDATA,
  output logic               RVALID,
  output logic               ISOLATION_LOOPBACK,
  output logic               LINE_ECHO_TEST,
  output logic               HYBRID_CONNECT,
  output logic               RECEIVE_PATH_ON,
  output logic               ONHOOK_MONITOR,
  output logic               LINE_OFFHOOK
);
  // hold counters live in 32-bit state fields and must load at least one
  if (RING_HOLD_CYC < 1)
  begin : g_ring_hold_check
    $error("ring hold count must be at least one cycle");
  end
  // the on-hook delay count must also load at least one; a zero delay is rejected here
  if (OFFHOOK_HOLD_CYC < 1)
  begin : g_hook_hold_check
    $error("on-hook delay count must be at least one cycle");
  end

  dcr_pkg::dcr_state_t s_reg;
  dcr_pkg::dcr_state_t s_next;
  logic                offhook_req;

  // status is only trusted while the link holds frame lock
  function automatic logic valid_status(input logic bit_in, input logic lock);
    return bit_in & lock; // R16
  endfunction

  // one step of a hold counter; it parks at zero instead of wrapping
  function automatic logic [31:0] count_down(input logic [31:0] cnt);
    logic [31:0] res;
    res = cnt;
    if (cnt != 32'h0)
      res = cnt - 32'h1;
    return res;
  endfunction

  // true when this request writes the given register
  function automatic logic write_hit(input dcr_pkg::dcr_req_t       req,
                                     input logic [`DCR_ADDR_W-1:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  // writable view of register one; the reset bit is never stored
  function automatic logic [7:0] main_write(input logic [7:0] wdata);
    logic [7:0] res;
    res = 8'h00; // R14
    res[`DCR_BIT_ISOLOOP] = wdata[`DCR_BIT_ISOLOOP]; // R3
    return res;
  endfunction

  // writable view of register two; reserved bits stay zero
  function automatic logic [7:0] path_write(input logic [7:0] wdata);
    logic [7:0] res;
    res = 8'h00; // R14
    res[`DCR_BIT_ECHO]   = wdata[`DCR_BIT_ECHO];   // R5
    res[`DCR_BIT_HYBRID] = wdata[`DCR_BIT_HYBRID]; // R6
    res[`DCR_BIT_RXON]   = wdata[`DCR_BIT_RXON];   // R6
    return res;
  endfunction

  // writable bits of the hook register: off-hook request above monitor
  function automatic logic [1:0] hook_write(input logic [7:0] wdata);
    return {wdata[`DCR_BIT_OFFHOOK], wdata[`DCR_BIT_MONITOR]}; // R9 R12
  endfunction

  // read view of the hook register; the negative and positive ring bits count only under frame lock
  function automatic logic [7:0] hook_view(input dcr_pkg::dcr_state_t st);
    logic [7:0] res;
    res = 8'h00; // R14
    res[`DCR_BIT_RNEG]     = valid_status(st.rneg_sync_reg[1], st.lock_sync_reg[1]); // R7
    res[`DCR_BIT_RPOS]     = valid_status(st.rpos_sync_reg[1], st.lock_sync_reg[1]); // R8
    res[`DCR_BIT_MONITOR]  = st.hook_bits_reg[0];
    res[`DCR_BIT_RPRESENT] = st.ring_present_reg; // R11
    res[`DCR_BIT_OFFHOOK]  = st.hook_bits_reg[1];
    return res;
  endfunction

  // read mux for the secondary frame; unlisted registers read zero
  function automatic logic [7:0] read_view(input dcr_pkg::dcr_state_t    st,
                                           input logic [`DCR_ADDR_W-1:0] addr);
    logic [7:0] res;
    case (addr)
      `DCR_OFF_MAIN: res = st.main_reg;
      `DCR_OFF_PATH: res = st.path_reg;
      `DCR_OFF_HOOK: res = hook_view(st);
      default:       res = 8'h00; // R14
    endcase
    return res;
  endfunction

  // next state: synchronisers, register writes, ring hold and hook sequence
  always_comb
  begin
    s_next = s_reg;
    offhook_req = 1'b0;
    // two flops for each line-side level before any logic reads it
    s_next.rneg_sync_reg = {s_reg.rneg_sync_reg[0], RING_NEG};
    s_next.rpos_sync_reg = {s_reg.rpos_sync_reg[0], RING_POS};
    s_next.lock_sync_reg = {s_reg.lock_sync_reg[0], FRAME_LOCK};
    s_next.pin_sync_reg  = {s_reg.pin_sync_reg[0], OFFHOOK_PIN};
    s_next.pin_en_reg    = PIN_HOOK_ENABLE;
    s_next.mode_reg      = MODE;
    s_next.rvalid_reg    = 1'b0;
    // effective request is the bit ORed with the enabled pin
    offhook_req = s_reg.hook_bits_reg[1]
                  | (s_reg.pin_en_reg & s_reg.pin_sync_reg[1]); // R12
    // ring present holds for the ring hold time after the last positive ring
    if (valid_status(s_reg.rpos_sync_reg[1], s_reg.lock_sync_reg[1]))
    begin
      s_next.ring_present_reg = 1'b1; // R11
      s_next.ring_cnt_reg = 32'(RING_HOLD_CYC);
    end
    else if (s_reg.ring_cnt_reg != 32'h0)
      s_next.ring_cnt_reg = count_down(s_reg.ring_cnt_reg);
    else
      s_next.ring_present_reg = 1'b0; // R11
    if (s_reg.hook_state_reg == dcr_pkg::HOOK_OFF)
    begin
      s_next.ring_present_reg = 1'b0; // R11
      s_next.ring_cnt_reg = 32'h0;
    end

    // hook sequence; the on-hook counter is skipped while mode is set
    case (s_reg.hook_state_reg)
      dcr_pkg::HOOK_ON:
        if (offhook_req)
          s_next.hook_state_reg = dcr_pkg::HOOK_OFF;
      dcr_pkg::HOOK_OFF:
        if (!offhook_req)
        begin
          if (s_reg.mode_reg)
            s_next.hook_state_reg = dcr_pkg::HOOK_ON; // R13
          else
          begin
            s_next.hook_state_reg = dcr_pkg::HOOK_DELAY;
            s_next.hook_cnt_reg = 32'(OFFHOOK_HOLD_CYC);
          end
        end
      dcr_pkg::HOOK_DELAY:
        if (s_reg.hook_cnt_reg <= 32'h1)
          s_next.hook_state_reg = dcr_pkg::HOOK_ON;
        else
          s_next.hook_cnt_reg = count_down(s_reg.hook_cnt_reg);
      default:
        s_next.hook_state_reg = dcr_pkg::HOOK_ON;
    endcase

    // line off-hook output is registered from the next hook state
    s_next.offhook_reg = (s_next.hook_state_reg == dcr_pkg::HOOK_OFF); // R12

    // register writes; reserved addresses and bits are dropped
    if (REQ.wr)
    begin
      case (REQ.addr)
        `DCR_OFF_MAIN:
          s_next.main_reg = main_write(REQ.wdata); // R3 R14
        `DCR_OFF_PATH:
          s_next.path_reg = path_write(REQ.wdata); // R5 R6
        `DCR_OFF_HOOK:
          s_next.hook_bits_reg = hook_write(REQ.wdata); // R9 R12
        default: ; // R2
      endcase
    end

    // reads return status for the secondary frame; a same-cycle write is not seen
    if (REQ.rd)
    begin
      s_next.rvalid_reg = 1'b1; // R15
      s_next.rdata_reg  = read_view(s_reg, REQ.addr); // R15
    end

    // software reset returns every register to reset and never stays set
    if (write_hit(REQ, `DCR_OFF_MAIN) && REQ.wdata[`DCR_BIT_SRESET])
    begin
      s_next.main_reg         = `DCR_RST_MAIN; // R1
      s_next.path_reg         = `DCR_RST_PATH; // R1
      s_next.hook_bits_reg    = 2'b00;         // R1
      s_next.ring_present_reg = 1'b0;
      s_next.ring_cnt_reg     = 32'h0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      s_reg <= '0;
      s_reg.main_reg <= `DCR_RST_MAIN;
      s_reg.path_reg <= `DCR_RST_PATH;
      s_reg.hook_state_reg <= dcr_pkg::HOOK_ON;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from flip-flops
  assign RDATA              = s_reg.rdata_reg;
  assign RVALID             = s_reg.rvalid_reg;
  assign ISOLATION_LOOPBACK = s_reg.main_reg[`DCR_BIT_ISOLOOP]; // R3
  assign LINE_ECHO_TEST     = s_reg.path_reg[`DCR_BIT_ECHO];    // R5
  assign HYBRID_CONNECT     = s_reg.path_reg[`DCR_BIT_HYBRID];  // R6
  assign RECEIVE_PATH_ON    = s_reg.path_reg[`DCR_BIT_RXON];    // R6
  assign ONHOOK_MONITOR     = s_reg.hook_bits_reg[0];           // R9
  assign LINE_OFFHOOK       = s_reg.offhook_reg;                // R12
endmodule

// ==== design/dcr_defs.svh ====
// offsets, field positions, reset values and timing counts for the line control register bank
// Functional notes
// R1: writing one to reset bit returns all registers to reset; bit self-clears
// R2: controller never writes reserved register addresses
// R3: isolation loopback bit enables digital loopback across barrier; zero disables it
// R4: controller powers up line side before setting isolation loopback
// R5: line echo test bit enables external analog loopback; zero disables it
// R6: hybrid connect bit connects transmit hybrid; receive bit enables receive path
// R7: negative ring status bit reads one while negative ring present
// R8: positive ring status bit reads one while positive ring present
// R9: on-hook monitor bit enables low-power monitoring without going off-hook
// R10: controller clears on-hook monitor before setting off-hook request
// R11: ring present reads one during ring; clears 4.5-9 s after ring or off-hook
// R12: off-hook bit drives off-hook; ORed with off-hook pin when pin enabled
// R13: while mode bit set, going on-hook does not start off-hook counter
// R14: reserved bits and reserved registers read zero
// R15: status bits are provided for reading through secondary frames
// R16: line-side status is treated invalid while frame lock clear
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH
`define DCR_ADDR_W          5
`define DCR_OFF_MAIN        5'h01
`define DCR_OFF_PATH        5'h02
`define DCR_OFF_RSV3        5'h03
`define DCR_OFF_RSV4        5'h04
`define DCR_OFF_HOOK        5'h05
`define DCR_RST_MAIN        8'h00
`define DCR_RST_PATH        8'h03
`define DCR_RST_HOOK        8'h00
`define DCR_BIT_SRESET      7
`define DCR_BIT_ISOLOOP     1
`define DCR_BIT_ECHO        3
`define DCR_BIT_HYBRID      1
`define DCR_BIT_RXON        0
`define DCR_BIT_RNEG        6
`define DCR_BIT_RPOS        5
`define DCR_BIT_MONITOR     3
`define DCR_BIT_RPRESENT    2
`define DCR_BIT_OFFHOOK     0
`define DCR_CLK_NS          4
`define DCR_RING_HOLD_MS    5000
`define DCR_OFFHOOK_HOLD_US 100
`endif

// ==== design/dcr_pkg.sv ====
// types for the line control register bank
package dcr_pkg;
  typedef enum logic [1:0] {HOOK_ON, HOOK_DELAY, HOOK_OFF} dcr_hook_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dcr_req_t;
  typedef struct packed {
    logic [7:0]      main_reg;
    logic [7:0]      path_reg;
    logic [1:0]      hook_bits_reg;
    logic            ring_present_reg;
    logic [31:0]     ring_cnt_reg;
    logic [31:0]     hook_cnt_reg;
    dcr_hook_t       hook_state_reg;
    logic [7:0]      rdata_reg;
    logic            rvalid_reg;
    logic [1:0]      rneg_sync_reg;
    logic [1:0]      rpos_sync_reg;
    logic [1:0]      lock_sync_reg;
    logic [1:0]      pin_sync_reg;
    logic            pin_en_reg;
    logic            mode_reg;
    logic            offhook_reg;
  } dcr_state_t;
endpackage

// ==== verif/dcr_regs_props.sv ====
// port assertions for the line control register bank
`timescale 1ns/100ps
module dcr_regs_props (
  input wire logic              CLOCK,
  input wire logic              RST_N,
  input wire dcr_pkg::dcr_req_t REQ,
  input wire logic [7:0]        RDATA,
  input wire logic              RVALID,
  input wire logic              ISOLATION_LOOPBACK,
  input wire logic              LINE_ECHO_TEST,
  input wire logic              HYBRID_CONNECT,
  input wire logic              RECEIVE_PATH_ON,
  input wire logic              ONHOOK_MONITOR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // answers and control levels one cycle after the request
  a_read_answer: assert property (REQ.rd |=> RVALID) else $error("read unanswered");
  a_stray_valid: assert property (RVALID |-> $past(REQ.rd)) else $error("stray valid");
  a_echo_write: assert property (REQ.wr && REQ.addr == 5'h02 |=>
    LINE_ECHO_TEST == $past(REQ.wdata[3])) else $error("echo bit wrong");
  a_path_write: assert property (REQ.wr && REQ.addr == 5'h02 |=>
    {HYBRID_CONNECT, RECEIVE_PATH_ON} == $past(REQ.wdata[1:0])) else $error("path bits wrong");
  a_loop_write: assert property (REQ.wr && REQ.addr == 5'h01 |=>
    ISOLATION_LOOPBACK == $past(REQ.wdata[1] & !REQ.wdata[7])) else $error("loop bit wrong");
  a_soft_reset: assert property (REQ.wr && REQ.addr == 5'h01 && REQ.wdata[7] |=>
    !LINE_ECHO_TEST && HYBRID_CONNECT && RECEIVE_PATH_ON && !ONHOOK_MONITOR)
    else $error("soft reset missed");
  a_monitor_write: assert property (REQ.wr && REQ.addr == 5'h05 |=>
    ONHOOK_MONITOR == $past(REQ.wdata[3])) else $error("monitor bit wrong");
  a_rsvd_reg: assert property (REQ.rd && !(REQ.addr inside {5'h01, 5'h02, 5'h05}) |=>
    RDATA == 8'h00) else $error("reserved reg not zero");
  a_main_bits: assert property (REQ.rd && REQ.addr == 5'h01 |=>
    (RDATA & 8'hFD) == 8'h00) else $error("reg one spare bits set");
endmodule

// ==== verif/dcr_dsp.sv ====
// controlling processor model issuing register requests
`timescale 1ns/100ps
module dcr_dsp (
  input  wire logic        CLOCK,
  input  wire logic [7:0]  RDATA,
  input  wire logic        RVALID,
  output dcr_pkg::dcr_req_t REQ
);
  initial REQ = '0;
  // one write held over one rising edge, then lines inverted
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    if (!(a inside {5'h01, 5'h02, 5'h05})) return;
    @(negedge CLOCK);
    REQ = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge CLOCK);
    REQ = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // one read; answer taken one cycle after the request
  task automatic rd(input logic [4:0] a, output logic [7:0] q, output logic v);
    @(negedge CLOCK);
    REQ = '{addr: a, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
    @(negedge CLOCK);
    q = RDATA;
    v = RVALID;
    REQ = '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
  endtask
endmodule

// ==== verif/dcr_regs_bench.sv ====
// self-checking bench for the line control register bank
`timescale 1ns/100ps
module dcr_regs_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rneg, rpos, lock, pin, pen, mode, v, rvalid, iso, echo, hyb, rx, mon, offh;
  logic [7:0] q, rdata;
  dcr_pkg::dcr_req_t req;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  dcr_regs #(.RING_HOLD_CYC(40), .OFFHOOK_HOLD_CYC(5)) dut (.CLOCK(clk), .RST_N(rst_n),
    .REQ(req), .RING_NEG(rneg), .RING_POS(rpos), .FRAME_LOCK(lock), .OFFHOOK_PIN(pin),
    .PIN_HOOK_ENABLE(pen), .MODE(mode), .RDATA(rdata), .RVALID(rvalid),
    .ISOLATION_LOOPBACK(iso), .LINE_ECHO_TEST(echo), .HYBRID_CONNECT(hyb),
    .RECEIVE_PATH_ON(rx), .ONHOOK_MONITOR(mon), .LINE_OFFHOOK(offh));
  dcr_dsp dsp (.CLOCK(clk), .RDATA(rdata), .RVALID(rvalid), .REQ(req));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    dsp.rd(a, q, v);
    chk({7'h00, v}, 8'h01);
    chk(q, e);
  endtask
  task automatic t_reset;
    rdc(5'h01, 8'h00);
    rdc(5'h02, 8'h03);
    for (int a = 3; a < 5; a++) rdc(5'(a), 8'h00);
    rdc(5'h1F, 8'h00);
  endtask
  task automatic t_paths;
    dsp.wr(5'h02, 8'h08);
    chk({5'h00, echo, hyb, rx}, 8'h04);
    dsp.wr(5'h02, 8'hFF);
    rdc(5'h02, 8'h0B);
    chk({5'h00, echo, hyb, rx}, 8'h07);
  endtask
  task automatic t_sreset;
    lock = 1'b1;
    dsp.wr(5'h01, 8'h02);
    dsp.wr(5'h05, 8'h08);
    chk({6'h00, iso, mon}, 8'h03);
    dsp.wr(5'h01, 8'h80);
    chk({3'h0, iso, mon, echo, hyb, rx}, 8'h03);
    rdc(5'h01, 8'h00);
  endtask
  task automatic t_ring;
    lock = 1'b1;
    rpos = 1'b1;
    repeat (4) @(negedge clk);
    rdc(5'h05, 8'h24);
    rpos = 1'b0;
    rneg = 1'b1;
    repeat (4) @(negedge clk);
    rdc(5'h05, 8'h44);
    lock = 1'b0;
    repeat (4) @(negedge clk);
    dsp.rd(5'h05, q, v);
    chk(q & 8'h60, 8'h00);
    lock = 1'b1;
    repeat (20) @(negedge clk);
    rdc(5'h05, 8'h44);
    repeat (23) @(negedge clk);
    rdc(5'h05, 8'h40);
  endtask
  task automatic t_hook;
    pin = 1'b1;
    repeat (5) @(negedge clk);
    chk({7'h00, offh}, 8'h00);
    dsp.wr(5'h05, 8'h01);
    @(negedge clk);
    chk({7'h00, offh}, 8'h01);
    pen = 1'b1;
    dsp.wr(5'h05, 8'h00);
    repeat (3) @(negedge clk);
    chk({7'h00, offh}, 8'h01);
    pen = 1'b0;
    dsp.wr(5'h05, 8'h01);
    @(negedge clk);
    chk({7'h00, offh}, 8'h00);
    repeat (10) @(negedge clk);
    chk({7'h00, offh}, 8'h01);
    mode = 1'b1;
    dsp.wr(5'h05, 8'h00);
    mode = 1'b0;
    dsp.wr(5'h05, 8'h01);
    @(negedge clk);
    chk({7'h00, offh}, 8'h01);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      print_verdict();
    end
  end
  // main sequence
  initial
  begin
    {rneg, rpos, lock, pin, pen, mode} = 6'h00;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_paths();
    t_sreset();
    t_ring();
    t_hook();
    print_verdict();
  end
endmodule
bind dcr_regs dcr_regs_props u_props (.CLOCK, .RST_N, .REQ, .RDATA, .RVALID, .ISOLATION_LOOPBACK,
  .LINE_ECHO_TEST, .HYBRID_CONNECT, .RECEIVE_PATH_ON, .ONHOOK_MONITOR);
